// ===== rtl/adcc_pkg.sv
// package: register indices, bit positions and timing constants of the converter control block
package adcc_pkg;
    // printed register offsets kept as indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'hC0;
    localparam logic [7:0] RESULT_IDX = 8'hC5;
    localparam logic [7:0] DIN_OFF_IDX = 8'hF6;
    localparam logic [7:0] IEN0_IDX = 8'hA8;
    localparam logic [7:0] IEN1_IDX = 8'hE8;
    localparam logic [7:0] PORT0_IDX = 8'h80;
    localparam int ADDR_W = 10;
    localparam int IDX_SHIFT = 2;
    // control and interrupt enable register fields
    localparam int BIT_POWER_ON = 7;
    localparam int BIT_DONE = 4;
    localparam int BIT_START = 3;
    localparam int BIT_RC_SEL = 2;
    localparam int BIT_CH_HI = 1;
    localparam int BIT_CH_LO = 0;
    localparam int BIT_GLOBAL_IE = 7;
    localparam int BIT_CONV_IE = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] CH_RESET = 2'h0;
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1000000));
    localparam int MC_CLOCKS = 6;
    localparam int CPU_CONV_TICKS = 31;
    localparam int RC_CONV_TICKS = 108;
    localparam int SAR_BITS = 8;
    localparam logic [7:0] SAR_FIRST = 8'h80;
    typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_type;
endpackage

// ===== rtl/adcc_top.sv
// module: converter control, status, result and port input disable behind an APB slave
`timescale 1ns/1ps
`default_nettype none

module adcc_top
    import adcc_pkg::*;
#(
    parameter int CPU_TICKS = CPU_CONV_TICKS,
    parameter int RC_TICKS = RC_CONV_TICKS
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic cmp_keep,
    input wire logic rc_tick,
    output logic [1:0] mux_select,
    output logic [7:0] trial_code,
    output logic converter_power_on,
    // port 0 digital path
    input wire logic [7:0] port0_pins,
    output logic [7:0] port0_read,
    output logic [7:0] port_digital_input_off,
    // system
    input wire logic power_down,
    input wire logic higher_irq_pending,
    output logic conv_irq
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {idx, {IDX_SHIFT{1'b0}}};
    endfunction

    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic power_on_q, done_q, busy_q, rc_sel_q, global_ie_q, conv_ie_q, irq_q;
    logic [1:0] chan_q, mux_q;
    logic [7:0] result_q, din_off_q, port_rd_q, sar_q, mask_q;
    logic [2:0] mc_div_q;
    logic [7:0] tick_cnt_q, per_cnt_q, mc_seen_q;
    adcc_state_type state_q;

    // bus decode
    wire logic access = psel & penable;
    wire logic hit_ctrl = reg_hit(paddr, CTRL_IDX);
    wire logic hit_res = reg_hit(paddr, RESULT_IDX);
    wire logic hit_doff = reg_hit(paddr, DIN_OFF_IDX);
    wire logic hit_ie0 = reg_hit(paddr, IEN0_IDX);
    wire logic hit_ie1 = reg_hit(paddr, IEN1_IDX);
    wire logic hit_port = reg_hit(paddr, PORT0_IDX);
    wire logic mapped = hit_ctrl | hit_res | hit_doff | hit_ie0 | hit_ie1 | hit_port;
    wire logic wr_en = access & pwrite & pready_q & mapped;
    wire logic w_ctrl = wr_en & hit_ctrl;
    wire logic [7:0] ctrl_rd = {power_on_q, 2'b00, done_q, busy_q, rc_sel_q, chan_q};
    wire logic [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                               hit_res ? result_q :
                               hit_doff ? din_off_q :
                               hit_ie0 ? {global_ie_q, 7'h00} :
                               hit_ie1 ? {3'h0, conv_ie_q, 4'h0} :
                               hit_port ? port_rd_q : RESET_BYTE;

    // start and channel handling
    wire logic start_req = w_ctrl & pwdata[BIT_START] & ~busy_q & ~done_q;
    wire logic clear_write = done_q & ~pwdata[BIT_DONE];
    wire logic chan_we = w_ctrl & ~busy_q & ~clear_write;

    // conversion timing: machine cycle ticks or rc ticks
    wire logic mc_tick = (mc_div_q == 3'(MC_CLOCKS - 1));
    wire logic conv_tick = rc_sel_q ? rc_tick : mc_tick;
    wire logic [7:0] total_ticks = rc_sel_q ? 8'(RC_TICKS) : 8'(CPU_TICKS);
    wire logic [7:0] bit_period = 8'(total_ticks >> 3);
    wire logic converting = (state_q == ADCC_CONV);
    wire logic abort = converting & power_down & ~rc_sel_q;
    wire logic decide = converting & conv_tick & (per_cnt_q == bit_period - 8'h01) & (mask_q != 8'h00);
    wire logic done_evt = converting & ~abort & conv_tick & (tick_cnt_q == total_ticks - 8'h01);
    // keep the trial bit when the input lies above the trial level
    wire logic [7:0] sar_decided = cmp_keep ? sar_q : (sar_q & ~mask_q);
    wire logic [7:0] sar_next = sar_decided | (mask_q >> 1);
    wire logic [7:0] final_code = decide ? sar_decided : sar_q;
    wire logic irq_d = done_q & global_ie_q & conv_ie_q & ~higher_irq_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q <= (access & ~pready_q & ~pwrite) ? {24'h000000, rd_byte} : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_q <= 1'b0;
            rc_sel_q <= 1'b0;
            chan_q <= CH_RESET;
            din_off_q <= RESET_BYTE;
            global_ie_q <= 1'b0;
            conv_ie_q <= 1'b0;
        end else begin
            if (w_ctrl) begin
                power_on_q <= pwdata[BIT_POWER_ON];
                rc_sel_q <= pwdata[BIT_RC_SEL];
            end
            if (chan_we) begin
                chan_q <= pwdata[BIT_CH_HI:BIT_CH_LO];
            end
            if (wr_en & hit_doff) begin
                din_off_q <= pwdata[7:0];
            end
            if (wr_en & hit_ie0) begin
                global_ie_q <= pwdata[BIT_GLOBAL_IE];
            end
            if (wr_en & hit_ie1) begin
                conv_ie_q <= pwdata[BIT_CONV_IE];
            end
        end
    end

    // done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= done_evt | (done_q & ~(w_ctrl & ~pwdata[BIT_DONE]));
            busy_q <= start_req | (busy_q & ~done_evt & ~abort);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ADCC_IDLE;
            mc_div_q <= '0;
            tick_cnt_q <= '0;
            per_cnt_q <= '0;
            sar_q <= '0;
            mask_q <= '0;
            result_q <= RESET_BYTE;
        end else begin
            mc_div_q <= mc_tick ? 3'h0 : mc_div_q + 3'h1;
            case (state_q)
                ADCC_IDLE: begin
                    if (start_req) begin
                        state_q <= ADCC_CONV;
                        tick_cnt_q <= '0;
                        per_cnt_q <= '0;
                        sar_q <= SAR_FIRST;
                        mask_q <= SAR_FIRST;
                    end
                end
                ADCC_CONV: begin
                    if (abort) begin
                        state_q <= ADCC_IDLE;
                        result_q <= sar_q;
                        mask_q <= '0;
                    end else if (done_evt) begin
                        state_q <= ADCC_IDLE;
                        result_q <= final_code;
                        mask_q <= '0;
                    end else if (conv_tick) begin
                        tick_cnt_q <= tick_cnt_q + 8'h01;
                        per_cnt_q <= decide ? 8'h00 : per_cnt_q + 8'h01;
                        if (decide) begin
                            sar_q <= sar_next;
                            mask_q <= mask_q >> 1;
                        end
                    end
                end
                default: begin
                    state_q <= ADCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_q <= CH_RESET;
            port_rd_q <= RESET_BYTE;
            irq_q <= 1'b0;
            mc_seen_q <= '0;
        end else begin
            mux_q <= chan_q;
            port_rd_q <= port0_pins & ~din_off_q;
            irq_q <= irq_d;
            mc_seen_q <= start_req ? 8'h00 : (busy_q & mc_tick ? mc_seen_q + 8'h01 : mc_seen_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mux_select = mux_q;
    assign trial_code = sar_q;
    assign converter_power_on = power_on_q;
    assign port0_read = port_rd_q;
    assign port_digital_input_off = din_off_q;
    assign conv_irq = irq_q;

    // cycle and decision counters that only the checks below read
    logic [9:0] conv_cyc_q;
    logic [3:0] dec_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cyc_q <= '0;
            dec_cnt_q <= '0;
        end else begin
            conv_cyc_q <= start_req ? '0 : ((busy_q && (conv_cyc_q != '1)) ? conv_cyc_q + 10'h001 : conv_cyc_q);
            dec_cnt_q <= start_req ? '0 : (decide ? dec_cnt_q + 4'h1 : dec_cnt_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_sets_busy_a: assert property (start_req |=> busy_q && ctrl_rd[BIT_START])
        else $error("start did not raise busy");
    done_pair_a: assert property (done_evt |=> done_q && !busy_q)
        else $error("completion did not swap busy for done");
    chan_freeze_a: assert property (busy_q && $past(busy_q) |-> $stable(chan_q))
        else $error("channel changed during conversion");
    result_hold_a: assert property (!$past(done_evt) && !$past(abort) |-> $stable(result_q))
        else $error("result changed without completion");
    irq_gate_a: assert property (conv_irq |-> $past(done_q && global_ie_q && conv_ie_q && !higher_irq_pending))
        else $error("interrupt without gated done flag");
    refuse_start_a: assert property (w_ctrl && pwdata[BIT_START] && done_q && !busy_q |=> !busy_q)
        else $error("start accepted while done flag set");
    cpu_length_a: assert property (done_evt && !rc_sel_q |-> mc_seen_q == 8'(CPU_TICKS - 1))
        else $error("cpu clocked conversion length wrong");
    port_mask_a: assert property ((port0_read & $past(din_off_q)) == 8'h00)
        else $error("disabled pin read as one");
    mux_route_a: assert property (##1 mux_select == $past(chan_q))
        else $error("mux does not follow channel select");
    pd_abort_a: assert property (power_down && converting && !rc_sel_q |=> !busy_q && !done_q)
        else $error("power down did not abort conversion");
    clear_keeps_chan_a: assert property (w_ctrl && done_q && !pwdata[BIT_DONE] |=> $stable(chan_q))
        else $error("flag clear changed channel");

    // start, busy and done
    busy_done_excl_a: assert property (!(busy_q && done_q))
        else $error("busy and done set together");
    state_busy_a: assert property (converting == busy_q)
        else $error("busy bit disagrees with conversion state");
    busy_hold_a: assert property (busy_q && !done_evt && !abort |=> busy_q)
        else $error("busy dropped during conversion");
    busy_start_a: assert property ($rose(busy_q) |-> $past(start_req))
        else $error("busy set without accepted start");
    done_hw_set_a: assert property ($rose(done_q) |-> $past(done_evt))
        else $error("done flag set without completion");
    done_keep_a: assert property (done_q && !(w_ctrl && !pwdata[BIT_DONE]) |=> done_q)
        else $error("done flag cleared by hardware");
    done_clear_a: assert property (w_ctrl && !pwdata[BIT_DONE] && !done_evt |=> !done_q)
        else $error("software clear of done flag lost");

    // channel and result
    chan_start_load_a: assert property (start_req |=> chan_q == $past(pwdata[BIT_CH_HI:BIT_CH_LO]))
        else $error("start write did not load channel");
    chan_busy_write_a: assert property (w_ctrl && busy_q |=> $stable(chan_q))
        else $error("write changed channel while busy");
    result_load_a: assert property (done_evt |=> result_q == $past(final_code))
        else $error("result not loaded at completion");
    result_idle_a: assert property (!converting |=> $stable(result_q))
        else $error("result changed while idle");
    refuse_keeps_result_a: assert property (w_ctrl && pwdata[BIT_START] && done_q |=> $stable(result_q))
        else $error("refused start disturbed result");
    abort_result_a: assert property (abort |=> result_q == $past(sar_q))
        else $error("abort did not leave partial code");
    abort_idle_a: assert property (abort |=> !converting)
        else $error("abort did not stop conversion");

    // successive approximation
    sar_first_a: assert property (start_req |=> trial_code == SAR_FIRST)
        else $error("conversion did not start at mid scale");
    mask_onehot_a: assert property (converting |-> $onehot0(mask_q))
        else $error("trial mask not one hot");
    sar_next_trial_a: assert property (decide && !done_evt && !abort |=>
        (trial_code & $past(mask_q >> 1)) == $past(mask_q >> 1))
        else $error("next trial bit not set");
    dec_count_a: assert property (done_evt |-> dec_cnt_q + 4'(decide) == 4'(SAR_BITS))
        else $error("wrong number of bit decisions");

    // conversion timing
    tick_bound_a: assert property (converting |-> tick_cnt_q < total_ticks)
        else $error("tick count ran past conversion length");
    cpu_cycles_a: assert property (done_evt && !rc_sel_q |->
        conv_cyc_q >= 10'(MC_CLOCKS * (CPU_TICKS - 1)) && conv_cyc_q < 10'(MC_CLOCKS * CPU_TICKS))
        else $error("cpu clocked conversion cycle count wrong");
    cpu_tick_only_a: assert property (converting && !rc_sel_q && !mc_tick |=> $stable(tick_cnt_q))
        else $error("cpu clocked conversion advanced off machine cycle");
    mc_div_bound_a: assert property (mc_div_q < 3'(MC_CLOCKS))
        else $error("machine cycle divider out of range");
    rc_tick_only_a: assert property (converting && rc_sel_q && !rc_tick |=> $stable(tick_cnt_q))
        else $error("rc clocked conversion advanced without rc tick");
    rc_sel_write_a: assert property (w_ctrl |=> rc_sel_q == $past(pwdata[BIT_RC_SEL]))
        else $error("clock source bit not written");

    // interrupt request
    irq_set_a: assert property (done_q && global_ie_q && conv_ie_q && !higher_irq_pending |=> conv_irq)
        else $error("enabled done flag raised no interrupt");
    irq_block_a: assert property (higher_irq_pending |=> !conv_irq)
        else $error("interrupt raised over higher priority");
    irq_clear_a: assert property (!done_q |=> !conv_irq)
        else $error("interrupt without done flag");

    // port digital path
    port_follow_a: assert property (##1 port0_read == $past(port0_pins & ~din_off_q))
        else $error("port read does not follow masked pins");
    din_write_a: assert property (wr_en && hit_doff |=> port_digital_input_off == $past(pwdata[7:0]))
        else $error("input disable register not written");
endmodule

`default_nettype wire

// ===== bench/adcc_analog_model.sv
// analog model: four input levels, comparator against the trial code and rc clock pulses
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
    // clock
    input wire logic pclk,
    // converter side
    input wire logic [1:0] mux_select,
    input wire logic [7:0] trial_code,
    input wire logic [35:0] vin_half_lsb,
    output logic cmp_keep,
    output logic rc_tick
);
    logic [8:0] vin;
    logic [1:0] div_q = 2'h0;
    // levels are in half steps; keep above trial minus half a step so the code rounds
    assign vin = vin_half_lsb[mux_select*9 +: 9];
    assign cmp_keep = ({1'b0, vin} + 10'h001) >= {1'b0, trial_code, 1'b0};
    always_ff @(posedge pclk) begin
        div_q <= div_q + 2'h1;
    end
    assign rc_tick = (div_q == 2'h2);
endmodule
`default_nettype wire

// ===== bench/adcc_top_tb_top.sv
// testbench: register access, conversions, refusals, interrupt, port disable and abort
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb_top;
    import adcc_pkg::*;
    localparam int TICKS = 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_keep, rc_tick, power_down, higher_irq_pending;
    logic conv_irq, converter_power_on, last_err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] mux_select;
    logic [7:0] trial_code, port0_pins, port0_read, port_digital_input_off;
    logic [35:0] vin = {9'h0AA, 9'h1FF, 9'h051, 9'h000};
    int bad_count = 0;
    int num_checks = 0;

    adcc_top #(.CPU_TICKS(TICKS), .RC_TICKS(TICKS)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_keep(cmp_keep),
        .rc_tick(rc_tick), .mux_select(mux_select), .trial_code(trial_code),
        .converter_power_on(converter_power_on), .port0_pins(port0_pins), .port0_read(port0_read),
        .port_digital_input_off(port_digital_input_off), .power_down(power_down),
        .higher_irq_pending(higher_irq_pending), .conv_irq(conv_irq)
    );
    adcc_analog_model model (
        .pclk(pclk), .mux_select(mux_select), .trial_code(trial_code), .vin_half_lsb(vin),
        .cmp_keep(cmp_keep), .rc_tick(rc_tick)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, CTRL_IDX, 32'h0);
            n++;
        end while (rd[BIT_DONE] !== 1'b1 && n < 200);
    endtask

    function automatic logic [31:0] exp_code(input logic [1:0] ch);
        logic [9:0] v;
        v = {1'b0, vin[ch*9 +: 9]} + 10'h001;
        return v[9] ? 32'h0FF : {23'h0, v[9:1]};
    endfunction

    task automatic t_reset();
        rdchk(CTRL_IDX, 32'h0);
        rdchk(RESULT_IDX, 32'h0);
        rdchk(DIN_OFF_IDX, 32'h0);
        rdchk(8'h10, 32'h0);
        chk(last_err, 1'b1);
    endtask

    task automatic t_conv(input logic [1:0] ch, input logic rcsel);
        logic [31:0] c;
        c = {24'h0, 3'b100, 2'b01, rcsel, ch};
        apb(1'b1, CTRL_IDX, c);
        rdchk(CTRL_IDX, c);
        chk(mux_select, ch);
        chk(converter_power_on, 1'b1);
        apb(1'b1, CTRL_IDX, c ^ 32'h3);
        rdchk(CTRL_IDX, c);
        wait_done();
        chk(rd, c ^ 32'h18);
        rdchk(RESULT_IDX, exp_code(ch));
        apb(1'b1, CTRL_IDX, c ^ 32'h13);
        rdchk(CTRL_IDX, c ^ 32'h1B);
        rdchk(RESULT_IDX, exp_code(ch));
        apb(1'b1, CTRL_IDX, c & 32'hE7);
        rdchk(CTRL_IDX, (c & 32'hE7) ^ 32'h3);
    endtask

    task automatic t_irq();
        apb(1'b1, IEN0_IDX, 32'h80);
        apb(1'b1, IEN1_IDX, 32'h10);
        apb(1'b1, CTRL_IDX, 32'h8A);
        wait_done();
        @(posedge pclk);
        chk(conv_irq, 1'b1);
        higher_irq_pending <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(conv_irq, 1'b0);
        higher_irq_pending <= 1'b0;
        apb(1'b1, CTRL_IDX, 32'h82);
        repeat (2) @(posedge pclk);
        chk(conv_irq, 1'b0);
    endtask

    task automatic t_port();
        port0_pins <= 8'hFF;
        apb(1'b1, DIN_OFF_IDX, 32'h78);
        rdchk(DIN_OFF_IDX, 32'h78);
        rdchk(PORT0_IDX, 32'h87);
        chk(port_digital_input_off, 8'h78);
        port0_pins <= 8'h5A;
        repeat (3) @(posedge pclk);
        chk(port0_read, 8'h02);
    endtask

    task automatic t_abort();
        apb(1'b1, CTRL_IDX, 32'h89);
        repeat (20) @(posedge pclk);
        power_down <= 1'b1;
        repeat (3) @(posedge pclk);
        power_down <= 1'b0;
        rdchk(CTRL_IDX, 32'h81);
        chk(conv_irq, 1'b0);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        {presetn, psel, penable, pwrite, power_down, higher_irq_pending} = 6'h0;
        paddr = '0;
        pwdata = 32'h0;
        port0_pins = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        apb(1'b1, CTRL_IDX, 32'h80);
        repeat (SETTLE_CYCLES) @(posedge pclk);
        for (int ch = 0; ch < 4; ch++) begin
            t_conv(ch[1:0], 1'b0);
        end
        t_conv(2'h1, 1'b1);
        t_irq();
        t_port();
        t_abort();
        report_and_stop();
    end
endmodule
`default_nettype wire
